// file: design/rptg_channel.sv
// One pulse-train channel: period counting, pulse counting, flags
`timescale 1ns/1ps
`default_nettype none
`include "rptg_defines.svh"
module rptg_channel (
   input  wire logic        sys_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic [3:0]  tick_vec_in,
   input  wire logic [1:0]  tick_select_in,
   input  wire logic [15:0] period_coeff_in,
   input  wire logic [31:0] pulse_count_limit_in,
   input  wire logic        gen_enable_in,
   input  wire logic        gen_reset_cmd_in,
   input  wire logic        fb_stop_in,
   input  wire logic        owned_in,
   output logic             level_out,
   output logic             gen_in_progress_out,
   output logic             gen_done_out,
   output logic [31:0]      pulses_out
);

   rptg_pkg::rptg_chan_s s_q;
   rptg_pkg::rptg_chan_s s_d;
   logic                 fast;
   logic                 tick;
   logic [16:0]          len;
   logic [16:0]          ton;
   logic [31:0]          pulses_inc;
   logic [16:0]          cnt_inc;
   logic                 run_ok;

   // ----------------------------------------------------------------
   // Period and high time in counted ticks
   // ----------------------------------------------------------------
   // Fast bases count half-ticks, so an odd coefficient still gives T/2
   assign fast       = tick_select_in < `RPTG_TB_SLOW_LO;
   assign tick       = tick_vec_in[tick_select_in];
   assign len        = fast ? {period_coeff_in, 1'b0} : {1'b0, period_coeff_in};
   assign ton        = fast ? {1'b0, period_coeff_in} : {2'b00, period_coeff_in[15:1]};
   assign pulses_inc = s_q.pulses + 32'h00000001;
   assign cnt_inc    = s_q.cnt + 17'h00001;
   assign run_ok     = owned_in && gen_enable_in && (len != 17'h00000);

   always_comb begin
      s_d = s_q;
      if (gen_reset_cmd_in) begin
         s_d = '0;
         s_d.st = rptg_pkg::RPTG_IDLE;
      end else begin
         case (s_q.st)
            rptg_pkg::RPTG_IDLE: begin
               s_d.level = 1'b0;
               if (run_ok && !fb_stop_in) begin
                  s_d.st    = rptg_pkg::RPTG_RUN;
                  s_d.cnt   = 17'h00000;
                  s_d.level = ton != 17'h00000;
               end
            end
            rptg_pkg::RPTG_RUN, rptg_pkg::RPTG_DRAIN: begin
               if (!run_ok) begin
                  s_d.st    = rptg_pkg::RPTG_IDLE;
                  s_d.level = 1'b0;
               end else begin
                  if (s_q.st == rptg_pkg::RPTG_RUN && fb_stop_in) begin
                     s_d.st = rptg_pkg::RPTG_DRAIN;
                  end else if (!fb_stop_in) begin
                     s_d.st = rptg_pkg::RPTG_RUN;
                  end
                  if (tick) begin
                     // Live period compare: a shrunk period wraps at once
                     if (s_q.cnt >= len - 17'h00001) begin
                        s_d.cnt    = 17'h00000;
                        s_d.pulses = pulses_inc;
                        s_d.level  = ton != 17'h00000;
                        if (pulse_count_limit_in != 32'h00000000 &&
                            pulses_inc >= pulse_count_limit_in) begin
                           s_d.st    = rptg_pkg::RPTG_DONE;
                           s_d.level = 1'b0;
                           s_d.done  = 1'b1;
                        end else if (s_q.st == rptg_pkg::RPTG_DRAIN) begin
                           s_d.st    = rptg_pkg::RPTG_IDLE;
                           s_d.level = 1'b0;
                        end
                     end else begin
                        s_d.cnt   = cnt_inc;
                        s_d.level = cnt_inc < ton;
                        if (s_q.st == rptg_pkg::RPTG_DRAIN && s_d.level != s_q.level) begin
                           s_d.st    = rptg_pkg::RPTG_IDLE;
                           s_d.level = 1'b0;
                        end
                     end
                  end
               end
            end
            rptg_pkg::RPTG_DONE: begin
               s_d.level = 1'b0;
            end
            default: begin
               s_d.st = rptg_pkg::RPTG_IDLE;
            end
         endcase
      end
      s_d.busy = (s_d.st == rptg_pkg::RPTG_RUN) || (s_d.st == rptg_pkg::RPTG_DRAIN);
   end

   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s_q    <= '0;
         s_q.st <= rptg_pkg::RPTG_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign level_out           = s_q.level;
   assign gen_in_progress_out = s_q.busy;
   assign gen_done_out        = s_q.done;
   assign pulses_out          = s_q.pulses;

endmodule
`default_nettype wire

// file: design/rptg_defines.svh
// Offsets, field positions, reset values and timing counts of the pulse-train block
`ifndef RPTG_DEFINES_SVH
`define RPTG_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RPTG_CLK_NS        25
`define RPTG_TB0_NS        127000
`define RPTG_TB1_NS        508000
`define RPTG_TB2_NS        10000000
`define RPTG_TB3_NS        1000000000
// Fast bases tick at half the base so the high time is exactly T/2
`define RPTG_TB0_CYC       (`RPTG_TB0_NS / (2 * `RPTG_CLK_NS))
`define RPTG_TB1_CYC       (`RPTG_TB1_NS / (2 * `RPTG_CLK_NS))
`define RPTG_TB2_CYC       (`RPTG_TB2_NS / `RPTG_CLK_NS)
`define RPTG_TB3_CYC       (`RPTG_TB3_NS / `RPTG_CLK_NS)

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RPTG_CH_STRIDE     8'h20
`define RPTG_OFS_CTRL      8'h00
`define RPTG_OFS_PERIOD    8'h04
`define RPTG_OFS_LIMIT     8'h08
`define RPTG_OFS_STATUS    8'h0C
`define RPTG_OFS_COUNT     8'h10
`define RPTG_OFS_DOUT      8'h40
`define RPTG_OFS_IRQ_STAT  8'h44
`define RPTG_OFS_IRQ_MASK  8'h48
`define RPTG_OFS_FAULT     8'h4C

// ----------------------------------------------------------------
// Control fields and codes
// ----------------------------------------------------------------
`define RPTG_CTRL_EN       0
`define RPTG_CTRL_RST      1
`define RPTG_CTRL_MODE_LO  2
`define RPTG_CTRL_TB_LO    4
`define RPTG_CTRL_FB_LO    6
`define RPTG_CTRL_RESET    8'h30
`define RPTG_MODE_PULSE    2'h1
`define RPTG_FB_STOP       2'h1
`define RPTG_FB_CONTINUE   2'h2
`define RPTG_TB_SLOW_LO    2'h2
`define RPTG_IRQ_FAULT     2

`endif

// file: design/rptg_pkg.sv
// Types shared by the pulse-train generator modules
package rptg_pkg;

   typedef enum logic [3:0] {
      RPTG_IDLE  = 4'h1,
      RPTG_RUN   = 4'h2,
      RPTG_DRAIN = 4'h4,
      RPTG_DONE  = 4'h8
   } rptg_state_e;

   typedef struct packed {
      rptg_state_e st;
      logic [16:0] cnt;
      logic [31:0] pulses;
      logic        level;
      logic        busy;
      logic        done;
   } rptg_chan_s;

   typedef struct packed {
      logic [3:0][25:0] cnt;
      logic [3:0]       tick;
   } rptg_tick_s;

   typedef struct packed {
      logic [1:0][7:0]  ctrl;
      logic [1:0][15:0] period;
      logic [1:0][31:0] limit;
      logic [1:0][1:0]  mode_act;
      logic [1:0]       dout;
      logic [2:0]       irq_stat;
      logic [2:0]       irq_mask;
      logic [1:0]       stop_sync;
      logic [1:0]       err_sync;
      logic             fault_prev;
      logic [1:0]       done_prev;
      logic [1:0]       pins;
      logic             irq;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
   } rptg_top_s;

endpackage

// file: design/rptg_tick_gen.sv
// Free-running time-base tick dividers, one enable pulse per base
`timescale 1ns/1ps
`default_nettype none
module rptg_tick_gen #(
   parameter logic [25:0] TB0_CYC = 26'h00009EC,
   parameter logic [25:0] TB1_CYC = 26'h00027B0,
   parameter logic [25:0] TB2_CYC = 26'h0061A80,
   parameter logic [25:0] TB3_CYC = 26'h2625A00
) (
   input  wire logic       sys_clk_in,
   input  wire logic       sys_rst_in,
   output logic [3:0]      tick_out
);

   rptg_pkg::rptg_tick_s s_q;
   rptg_pkg::rptg_tick_s s_d;
   logic [3:0][25:0]     lim;

   assign lim = {TB3_CYC, TB2_CYC, TB1_CYC, TB0_CYC};

   // ----------------------------------------------------------------
   // Dividers
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      for (int i = 0; i < 4; i++) begin
         s_d.tick[i] = 1'b0;
         if (s_q.cnt[i] >= lim[i] - 26'h0000001) begin
            s_d.cnt[i]  = 26'h0000000;
            s_d.tick[i] = 1'b1;
         end else begin
            s_d.cnt[i] = s_q.cnt[i] + 26'h0000001;
         end
      end
   end

   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_out = s_q.tick;

endmodule
`default_nettype wire

// file: design/rptg_top.sv
// Two-channel pulse-train generator with APB registers and interrupt
//
// Overview of operation
// - Two channels drive dedicated outputs zero and one
// - Output starts only after reset command and enable
// - Operating mode latched only on reset command
// - Four tick bases selectable, slowest is default
// - Nonzero pulse limit stops train, zero runs forever
// - Enable low inhibits and clears in-progress
// - Reset command clears flags and pulse count
// - In-progress high exactly while pulses are driven
// - Done set at limit, held until reset command
// - Period equals coefficient times tick
// - High time half period, slow bases truncate
// - Coefficient changes act immediately
// - Plain output writes ignored while generator owns pin
// - Fallback reset clears, continue keeps running
// - Fallback stop ends current interval then halts
// - Status bit 0 in-progress, bit 1 done
`timescale 1ns/1ps
`default_nettype none
`include "rptg_defines.svh"
module rptg_top #(
   parameter logic [25:0] TB0_CYC = 26'(`RPTG_TB0_CYC),
   parameter logic [25:0] TB1_CYC = 26'(`RPTG_TB1_CYC),
   parameter logic [25:0] TB2_CYC = 26'(`RPTG_TB2_CYC),
   parameter logic [25:0] TB3_CYC = 26'(`RPTG_TB3_CYC)
) (
   input  wire logic        sys_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        plc_stop_in,
   input  wire logic        comm_error_in,
   output logic             dedicated_out_zero_out,
   output logic             dedicated_out_one_out,
   output logic             irq_out
);

   rptg_pkg::rptg_top_s s_q;
   rptg_pkg::rptg_top_s s_d;

   logic [3:0]       ticks;
   logic [1:0]       level;
   logic [1:0]       busy;
   logic [1:0]       done;
   logic [1:0][31:0] pulses;
   logic [1:0]       owned;
   logic [1:0]       rst_eff;
   logic [1:0]       fb_stop;
   logic             fault;
   logic             acc;
   logic             wr_go;

   // ----------------------------------------------------------------
   // Address decode helpers
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   function automatic logic [7:0] ch_ofs(input int ch, input logic [7:0] ofs);
      ch_ofs = 8'(ch * `RPTG_CH_STRIDE) + ofs;
   endfunction

   function automatic logic [1:0] fb_code(input logic [7:0] ctrl);
      fb_code = ctrl[`RPTG_CTRL_FB_LO +: 2];
   endfunction

   // ----------------------------------------------------------------
   // Fault condition and fallback decode
   // ----------------------------------------------------------------
   // Pins from the link side pass two flops before use
   assign fault = s_q.stop_sync[1] | s_q.err_sync[1];

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         // Codes other than stop and continue fall back to reset
         fb_stop[i] = fault && (fb_code(s_q.ctrl[i]) == `RPTG_FB_STOP);
         rst_eff[i] = s_q.ctrl[i][`RPTG_CTRL_RST] ||
                      (fault && fb_code(s_q.ctrl[i]) != `RPTG_FB_STOP &&
                       fb_code(s_q.ctrl[i]) != `RPTG_FB_CONTINUE);
         owned[i]   = s_q.mode_act[i] == `RPTG_MODE_PULSE;
      end
   end

   // ----------------------------------------------------------------
   // Time bases and channels
   // ----------------------------------------------------------------
   rptg_tick_gen #(
      .TB0_CYC (TB0_CYC),
      .TB1_CYC (TB1_CYC),
      .TB2_CYC (TB2_CYC),
      .TB3_CYC (TB3_CYC)
   ) u_ticks (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .tick_out   (ticks)
   );

   generate
      for (genvar g = 0; g < 2; g++) begin : g_ch
         rptg_channel u_ch (
            .sys_clk_in           (sys_clk_in),
            .sys_rst_in           (sys_rst_in),
            .tick_vec_in          (ticks),
            .tick_select_in       (s_q.ctrl[g][`RPTG_CTRL_TB_LO +: 2]),
            .period_coeff_in      (s_q.period[g]),
            .pulse_count_limit_in (s_q.limit[g]),
            .gen_enable_in        (s_q.ctrl[g][`RPTG_CTRL_EN]),
            .gen_reset_cmd_in     (rst_eff[g]),
            .fb_stop_in           (fb_stop[g]),
            .owned_in             (owned[g]),
            .level_out            (level[g]),
            .gen_in_progress_out  (busy[g]),
            .gen_done_out         (done[g]),
            .pulses_out           (pulses[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // APB slave and register state
   // ----------------------------------------------------------------
   // Access phase is two cycles: pready rises one edge after penable
   assign acc   = psel_in && penable_in && !s_q.pready;
   assign wr_go = psel_in && penable_in && s_q.pready && pwrite_in && !s_q.pslverr;

   always_comb begin
      logic [2:0] ev;
      logic [2:0] clr;
      logic       mapped;
      logic [31:0] rd;
      ev     = 3'h0;
      clr    = 3'h0;
      mapped = 1'b0;
      rd     = 32'h00000000;
      s_d    = s_q;

      s_d.stop_sync = {s_q.stop_sync[0], plc_stop_in};
      s_d.err_sync  = {s_q.err_sync[0], comm_error_in};

      // Read mux and map check
      for (int i = 0; i < 2; i++) begin
         if (hit(paddr_in, ch_ofs(i, `RPTG_OFS_CTRL))) begin
            mapped = 1'b1;
            rd     = {24'h000000, s_q.ctrl[i]};
         end else if (hit(paddr_in, ch_ofs(i, `RPTG_OFS_PERIOD))) begin
            mapped = 1'b1;
            rd     = {16'h0000, s_q.period[i]};
         end else if (hit(paddr_in, ch_ofs(i, `RPTG_OFS_LIMIT))) begin
            mapped = 1'b1;
            rd     = s_q.limit[i];
         end else if (hit(paddr_in, ch_ofs(i, `RPTG_OFS_STATUS))) begin
            mapped = 1'b1;
            rd     = {28'h0000000, s_q.mode_act[i], done[i], busy[i]};
         end else if (hit(paddr_in, ch_ofs(i, `RPTG_OFS_COUNT))) begin
            mapped = 1'b1;
            rd     = pulses[i];
         end
      end
      if (hit(paddr_in, `RPTG_OFS_DOUT)) begin
         mapped = 1'b1;
         rd     = {30'h00000000, s_q.dout};
      end else if (hit(paddr_in, `RPTG_OFS_IRQ_STAT)) begin
         mapped = 1'b1;
         rd     = {29'h00000000, s_q.irq_stat};
      end else if (hit(paddr_in, `RPTG_OFS_IRQ_MASK)) begin
         mapped = 1'b1;
         rd     = {29'h00000000, s_q.irq_mask};
      end else if (hit(paddr_in, `RPTG_OFS_FAULT)) begin
         mapped = 1'b1;
         rd     = {30'h00000000, s_q.err_sync[1], s_q.stop_sync[1]};
      end

      // Response stands for the ready cycle only, zero otherwise
      s_d.pready  = acc;
      s_d.pslverr = acc && !mapped;
      s_d.prdata  = (acc && mapped && !pwrite_in) ? rd : 32'h00000000;

      // Writes take effect at the edge that completes the transfer
      if (wr_go) begin
         for (int i = 0; i < 2; i++) begin
            if (hit(paddr_in, ch_ofs(i, `RPTG_OFS_CTRL))) begin
               s_d.ctrl[i] = pwdata_in[7:0];
            end else if (hit(paddr_in, ch_ofs(i, `RPTG_OFS_PERIOD))) begin
               s_d.period[i] = pwdata_in[15:0];
            end else if (hit(paddr_in, ch_ofs(i, `RPTG_OFS_LIMIT))) begin
               s_d.limit[i] = pwdata_in;
            end
         end
         if (hit(paddr_in, `RPTG_OFS_DOUT)) begin
            s_d.dout = pwdata_in[1:0];
         end else if (hit(paddr_in, `RPTG_OFS_IRQ_STAT)) begin
            clr = pwdata_in[2:0];
         end else if (hit(paddr_in, `RPTG_OFS_IRQ_MASK)) begin
            s_d.irq_mask = pwdata_in[2:0];
         end
      end

      // Mode takes effect only while the reset command is active
      for (int i = 0; i < 2; i++) begin
         if (rst_eff[i]) begin
            s_d.mode_act[i] = s_q.ctrl[i][`RPTG_CTRL_MODE_LO +: 2];
         end
         // Generator owns its pin; the plain output bit only applies otherwise
         s_d.pins[i] = owned[i] ? level[i] : s_q.dout[i];
      end

      // Interrupt events: done rising per channel, fault rising
      s_d.done_prev  = done;
      s_d.fault_prev = fault;
      ev[1:0]        = done & ~s_q.done_prev;
      ev[`RPTG_IRQ_FAULT] = fault && !s_q.fault_prev;
      // A new event beats a clear in the same cycle
      s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
      s_d.irq      = |(s_d.irq_stat & s_q.irq_mask);
   end

   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s_q         <= '0;
         s_q.ctrl[0] <= `RPTG_CTRL_RESET;
         s_q.ctrl[1] <= `RPTG_CTRL_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata_out             = s_q.prdata;
   assign pready_out             = s_q.pready;
   assign pslverr_out            = s_q.pslverr;
   assign dedicated_out_zero_out = s_q.pins[0];
   assign dedicated_out_one_out  = s_q.pins[1];
   assign irq_out                = s_q.irq;

endmodule
`default_nettype wire

// file: dv/rptg_checker.sv
// Bus and interrupt checks on the pulse-train top ports
`timescale 1ns/1ps
`default_nettype none
module rptg_checker (
   input wire logic        sys_clk_in,
   input wire logic        sys_rst_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic        irq_out
);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (sys_rst_in);
   property p_rdy_resp;
      psel_in && penable_in && !pready_out |=> pready_out;
   endproperty
   a_rdy_resp: assert property (p_rdy_resp) else $error("no ready after access");
   property p_rdy_cause;
      pready_out |-> $past(psel_in && penable_in);
   endproperty
   a_rdy_cause: assert property (p_rdy_cause) else $error("ready without access");
   property p_rdy_pulse;
      pready_out |=> !pready_out;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held");
   property p_data_idle;
      !pready_out |-> prdata_out == 32'h0;
   endproperty
   a_data_idle: assert property (p_data_idle) else $error("read data outside ready");
   property p_err_unmapped;
      pready_out && paddr_in >= 8'h50 |-> pslverr_out;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("no error");
   property p_err_status;
      pready_out && paddr_in == 8'h0C |-> !pslverr_out;
   endproperty
   a_err_status: assert property (p_err_status) else $error("status refused");
   property p_err_alone;
      pslverr_out |-> pready_out;
   endproperty
   a_err_alone: assert property (p_err_alone) else $error("error without ready");
   // Sticky status only drops through a bus write
   property p_irq_fall;
      $fell(irq_out) |-> $past(pready_out) || $past(pready_out, 2) || $past(pready_out, 3);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped alone");
endmodule
`default_nettype wire

// file: dv/rptg_plc_model.sv
// Controller-side fault source: stop and link-error levels
`timescale 1ns/1ps
`default_nettype none
module rptg_plc_model (
   input  wire logic sys_clk_in,
   input  wire logic stop_cmd_in,
   input  wire logic err_cmd_in,
   output logic      plc_stop_out,
   output logic      comm_error_out
);
   // Levels change only after a clock edge, like the real link
   always_ff @(posedge sys_clk_in) begin
      plc_stop_out   <= stop_cmd_in;
      comm_error_out <= err_cmd_in;
   end
endmodule
`default_nettype wire

// file: dv/test_rptg_top.sv
// Self-checking bench for the two-channel pulse-train block
`timescale 1ns/1ps
`default_nettype none
module test_rptg_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        prdy;
   logic        perr;
   logic        last_err;
   logic        stop_cmd = 1'b0;
   logic        err_cmd = 1'b0;
   logic        stop;
   logic        cerr;
   logic        q0;
   logic        q1;
   logic        irq;
   int          fail_count = 0;
   int          samples_checked = 0;
   always #12.5 clk = ~clk;
   // Short ticks keep the run brief: 4, 8, 10, 20 cycles
   rptg_top #(.TB0_CYC(26'h4), .TB1_CYC(26'h8), .TB2_CYC(26'hA), .TB3_CYC(26'h14)) rptg_top_inst (
      .sys_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(prdy), .pslverr_out(perr), .plc_stop_in(stop), .comm_error_in(cerr),
      .dedicated_out_zero_out(q0), .dedicated_out_one_out(q1), .irq_out(irq));
   rptg_plc_model rptg_plc_model_inst (.sys_clk_in(clk), .stop_cmd_in(stop_cmd),
      .err_cmd_in(err_cmd), .plc_stop_out(stop), .comm_error_out(cerr));
   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string m);
      samples_checked++;
      if (act !== exp) begin
         fail_count++;
         $display("mismatch %0t %s got %0h exp %0h", $time, m, act, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (prdy !== 1'b1);
      r = prdata;
      last_err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      apb(1'b1, a, d, v);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      apb(1'b0, a, 32'h0, v);
      chk(v, exp, "register read");
   endtask
   function automatic logic pin(input int s);
      return s ? q1 : q0;
   endfunction
   // First phase may be cut short by the free dividers, so the second is judged
   task automatic meas(input int s, input int hi_e, input int per_e);
      int n;
      int hi;
      int per;
      repeat (2) begin
         n = 0;
         while (pin(s) !== 1'b0 && n < 900) begin @(posedge clk); n++; end
         while (pin(s) !== 1'b1 && n < 900) begin @(posedge clk); n++; end
         hi = 0;
         while (pin(s) === 1'b1 && n < 900) begin @(posedge clk); n++; hi++; end
         per = hi;
         while (pin(s) === 1'b0 && n < 900) begin @(posedge clk); n++; per++; end
         chk(n < 900, 1'b1, "pin activity");
      end
      chk(hi, hi_e, "high time");
      chk(per, per_e, "period");
   endtask
   task automatic rises(input int cyc, output int c);
      logic p;
      c = 0;
      p = q0;
      repeat (cyc) begin
         @(posedge clk);
         if (q0 === 1'b1 && p !== 1'b1) c++;
         p = q0;
      end
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_and_mode;
      rd(8'h00, 32'h30);
      rd(8'h08, 32'h0);
      rd(8'h50, 32'h0);
      chk(last_err, 1'b1, "unmapped error");
      wr(8'h04, 32'h6);
      wr(8'h00, 32'h05);
      repeat (40) @(posedge clk);
      rd(8'h0C, 32'h0);
      wr(8'h00, 32'h07);
      wr(8'h00, 32'h05);
      rd(8'h0C, 32'h5);
   endtask
   task automatic t_period;
      meas(0, 24, 48);
      wr(8'h40, 32'h3);
      meas(0, 24, 48);
      chk(q1, 1'b1, "plain output on free pin");
      wr(8'h04, 32'h4);
      meas(0, 16, 32);
      wr(8'h00, 32'h15);
      meas(0, 32, 64);
      wr(8'h00, 32'h04);
      // Pin lags the channel by one register stage
      repeat (3) @(posedge clk);
      chk(q0, 1'b0, "pin after disable");
      rd(8'h0C, 32'h4);
   endtask
   task automatic t_limit;
      int c;
      wr(8'h08, 32'h3);
      wr(8'h48, 32'h1);
      wr(8'h00, 32'h07);
      wr(8'h00, 32'h05);
      rises(400, c);
      chk(c, 3, "pulse count");
      rd(8'h0C, 32'h6);
      rd(8'h10, 32'h3);
      chk(irq, 1'b1, "done interrupt");
      wr(8'h44, 32'h1);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0, "interrupt cleared");
      wr(8'h48, 32'h0);
      wr(8'h00, 32'h07);
      rd(8'h0C, 32'h4);
      rd(8'h10, 32'h0);
   endtask
   task automatic t_slow_ch1;
      // Small odd coefficient on purpose: exercises truncation, not precision
      wr(8'h24, 32'h5);
      wr(8'h20, 32'h27);
      wr(8'h20, 32'h25);
      meas(1, 20, 50);
      chk(q0, 1'b0, "other pin idle");
      wr(8'h20, 32'h24);
   endtask
   task automatic t_fallback;
      int c;
      wr(8'h08, 32'h0);
      for (int fb = 0; fb < 4; fb++) begin
         wr(8'h00, 32'(fb * 64 + 7));
         wr(8'h00, 32'(fb * 64 + 5));
         repeat (20) @(posedge clk);
         stop_cmd <= fb[0];
         err_cmd <= !fb[0];
         repeat (60) @(posedge clk);
         rises(100, c);
         chk(c != 0, fb == 2, "running under fault");
         rd(8'h0C, (fb == 2) ? 32'h5 : 32'h4);
         chk(irq, 1'b0, "fault masked");
         stop_cmd <= 1'b0;
         err_cmd <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   task automatic print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset_and_mode();
      t_period();
      t_limit();
      t_slow_ch1();
      t_fallback();
      print_verdict();
   end
   initial begin
      #1000000;
      fail_count++;
      print_verdict();
   end
endmodule
bind rptg_top rptg_checker rptg_checker_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
   .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out));
`default_nettype wire
